// ### bench/tb_top.sv
// Purpose: self-checking bench for the trace capture block
// Assumes: inputs change at the falling edge
// Notes: trigger and read-valid pulses are counted by monitors
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_top;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    tcr_pkg::tcr_cfg_type cfg = '0;
    logic enable = 1'b1;
    logic arm_set = 1'b0;
    logic rd = 1'b0;
    tcr_pkg::tcr_bus_type bus;
    tcr_pkg::tcr_cof_type cof;
    logic exec;
    logic [15:0] exec_addr;
    logic [15:0] rd_data;
    logic rd_valid;
    logic armed;
    logic [2:0] flags;
    logic [6:0] count;
    logic trig;
    logic [15:0] comp_c;
    logic c_brk;
    int err_total = 0;
    int checks_done = 0;
    int trig_cnt = 0;
    int rdv_cnt = 0;
    logic [15:0] d;
    always #5 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        if (trig === 1'b1) trig_cnt++;
        if (rd_valid === 1'b1) rdv_cnt++;
    end
    tcr_core_model core (.ref_clk_i(ref_clk_i), .bus_o(bus), .cof_o(cof), .exec_o(exec), .exec_addr_o(exec_addr));
    tcr_trace uut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cfg_i(cfg), .enable_i(enable), .arm_set_i(arm_set),
        .bus_i(bus), .cof_i(cof), .exec_i(exec), .exec_addr_i(exec_addr), .rd_i(rd), .rd_data_o(rd_data),
        .rd_valid_o(rd_valid), .armed_o(armed), .match_status_reg_o(flags), .valid_word_count_o(count),
        .trig_o(trig), .comp_c_o(comp_c), .c_break_en_o(c_brk));
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic set_cfg(input tcr_pkg::tcr_trig_type t, input tcr_pkg::tcr_cap_type c, input logic [15:0] a);
        cfg.trigger_mode_field = t;
        cfg.cap = c;
        cfg.begin_trg = 1'b0;
        cfg.cmp_a = a;
        cfg.cmp_b = 16'h2000;
    endtask
    task automatic arm();
        @(negedge ref_clk_i) arm_set = 1'b1;
        @(negedge ref_clk_i) arm_set = 1'b0;
        @(negedge ref_clk_i);
    endtask
    // one 16-bit read of the window
    task automatic rd_word(output logic [15:0] v);
        @(negedge ref_clk_i) rd = 1'b1;
        @(negedge ref_clk_i) rd = 1'b0;
        @(negedge ref_clk_i) v = rd_data;
    endtask
    task automatic t_profile();
        set_cfg(tcr_pkg::A_ONLY, tcr_pkg::CAP_PROFILE, 16'h1000);
        arm();
        `CHK("prof armed", 1'b0, armed)
        core.exec_event(16'h0776);
        core.exec_event(16'h0778);
        rd_word(d);
        `CHK("prof data", 16'h0778, d)
        `CHK("prof count", 7'h00, count)
        `CHK("prof c brk", 1'b0, c_brk)
    endtask
    task automatic t_end_normal();
        trig_cnt = 0;
        rdv_cnt = 0;
        set_cfg(tcr_pkg::A_ONLY, tcr_pkg::CAP_NORMAL, 16'h1000);
        arm();
        `CHK("end armed", 1'b1, armed)
        `CHK("end flags", 3'h0, flags)
        `CHK("end count", 7'h00, count)
        core.cof_event(tcr_pkg::COF_SRC, 1'b0, 16'h0410);
        core.cof_event(tcr_pkg::COF_DST, 1'b0, 16'h0520);
        core.cof_event(tcr_pkg::COF_VEC, 1'b1, 16'hfff6);
        core.cof_event(tcr_pkg::COF_VEC, 1'b0, 16'hffe8);
        core.bus_cycle(tcr_pkg::CYC_DATA, 16'h1000, 16'h0000);
        `CHK("end trig flag", 3'h1, flags)
        `CHK("end disarm", 1'b0, armed)
        `CHK("end trig", 1, trig_cnt)
        `CHK("end stored", 7'h03, count)
        rd_word(d);
        `CHK("rd 0", 16'h0410, d)
        rd_word(d);
        `CHK("rd 1", 16'h0520, d)
        rd_word(d);
        `CHK("rd 2", 16'hffe8, d)
        `CHK("rd count", 7'h03, count)
        `CHK("rd valid", 3, rdv_cnt)
    endtask
    task automatic t_range(input tcr_pkg::tcr_trig_type t, input logic [15:0] miss, input logic [15:0] hit,
        input logic [2:0] fl);
        trig_cnt = 0;
        rdv_cnt = 0;
        set_cfg(t, tcr_pkg::CAP_NORMAL, 16'h1001);
        arm();
        core.bus_cycle(tcr_pkg::CYC_DATA, miss, 16'h0000);
        `CHK("rng miss flags", 3'h0, flags)
        `CHK("rng miss armed", 1'b1, armed)
        rd_word(d);
        `CHK("armed rd data", 16'hffff, d)
        `CHK("armed rd valid", 0, rdv_cnt)
        core.bus_cycle(tcr_pkg::CYC_DATA, hit, 16'h0000);
        `CHK("rng hit flags", fl, flags)
        `CHK("rng trig", 1, trig_cnt)
    endtask
    task automatic t_loop();
        set_cfg(tcr_pkg::A_ONLY, tcr_pkg::CAP_LOOP, 16'h1000);
        arm();
        `CHK("loop c clear", 16'h0000, comp_c)
        `CHK("loop c brk", 1'b0, c_brk)
        core.cof_event(tcr_pkg::COF_SRC, 1'b0, 16'h0400);
        core.cof_event(tcr_pkg::COF_SRC, 1'b0, 16'h0400);
        `CHK("loop c load", 16'h0400, comp_c)
        `CHK("loop c hit", 3'h4, flags)
        core.cof_event(tcr_pkg::COF_DST, 1'b0, 16'h0500);
        core.cof_event(tcr_pkg::COF_DST, 1'b0, 16'h0500);
        `CHK("loop count", 7'h03, count)
    endtask
    task automatic t_detail();
        set_cfg(tcr_pkg::A_ONLY, tcr_pkg::CAP_DETAIL, 16'h1000);
        arm();
        core.bus_cycle(tcr_pkg::CYC_PROG, 16'h0300, 16'h1111);
        core.bus_cycle(tcr_pkg::CYC_FREE, 16'h0302, 16'h2222);
        core.bus_cycle(tcr_pkg::CYC_DATA, 16'h0600, 16'habcd);
        `CHK("det count", 7'h02, count)
        core.bus_cycle(tcr_pkg::CYC_DATA, 16'h1000, 16'h0000);
        rd_word(d);
        `CHK("det addr", 16'h0600, d)
        rd_word(d);
        `CHK("det data", 16'habcd, d)
        set_cfg(tcr_pkg::EV_B, tcr_pkg::CAP_DETAIL, 16'h1000);
        arm();
        core.bus_cycle(tcr_pkg::CYC_DATA, 16'h0700, 16'h1234);
        core.bus_cycle(tcr_pkg::CYC_DATA, 16'h2000, 16'h5678);
        `CHK("det evb flags", 3'h2, flags)
        `CHK("det evb disarm", 1'b0, armed)
        `CHK("det evb count", 7'h02, count)
    endtask
    task automatic t_event_b();
        set_cfg(tcr_pkg::EV_B, tcr_pkg::CAP_NORMAL, 16'h1000);
        arm();
        for (int i = 0; i < 64; i++) core.bus_cycle(tcr_pkg::CYC_DATA, 16'h2000, 16'(16'h0100 + i));
        `CHK("evb count", 7'h40, count)
        `CHK("evb disarm", 1'b0, armed)
        `CHK("evb flag b", 1'b1, flags[1])
        for (int i = 0; i < 64; i++) begin
            rd_word(d);
            `CHK("evb data", 16'(16'h0100 + i), d)
        end
        rd_word(d);
        `CHK("evb wrap", 16'h0100, d)
    endtask
    // tagged inside range: word granularity, direction enables ignored
    task automatic t_tag_range();
        trig_cnt = 0;
        set_cfg(tcr_pkg::INSIDE, tcr_pkg::CAP_NORMAL, 16'h1001);
        cfg.tag_trigger_select = 1'b1;
        cfg.dir_compare_enable_a = 1'b1;
        cfg.dir_compare_enable_b = 1'b1;
        arm();
        core.exec_event(16'h0ffe);
        core.bus_cycle(tcr_pkg::CYC_DATA, 16'h1800, 16'h0000);
        `CHK("tag miss flags", 3'h0, flags)
        core.exec_event(16'h1000);
        @(negedge ref_clk_i);
        `CHK("tag word flags", 3'h3, flags)
        `CHK("tag dir ignored", 1, trig_cnt)
        cfg.tag_trigger_select = 1'b0;
        cfg.dir_compare_enable_a = 1'b0;
        cfg.dir_compare_enable_b = 1'b0;
    endtask
    // end mode past 64 entries keeps the newest 64
    task automatic t_wrap();
        set_cfg(tcr_pkg::A_THEN_B, tcr_pkg::CAP_NORMAL, 16'h1000);
        arm();
        core.bus_cycle(tcr_pkg::CYC_DATA, 16'h2000, 16'h0000);
        core.bus_cycle(tcr_pkg::CYC_DATA, 16'h1000, 16'h0000);
        `CHK("then a only", 3'h1, flags)
        `CHK("then armed", 1'b1, armed)
        for (int i = 0; i < 66; i++) core.cof_event(tcr_pkg::COF_DST, 1'b0, 16'(16'h0400 + i));
        core.bus_cycle(tcr_pkg::CYC_DATA, 16'h2000, 16'h0000);
        `CHK("then flags", 3'h3, flags)
        `CHK("wrap count", 7'h40, count)
        rd_word(d);
        `CHK("wrap oldest", 16'h0402, d)
    endtask
    initial begin
        #100000;
        err_total++;
        finish_test();
    end
    initial begin
        repeat (4) @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        @(negedge ref_clk_i);
        `CHK("rst armed", 1'b0, armed)
        `CHK("rst rd data", 16'hffff, rd_data)
        `CHK("rst count", 7'h00, count)
        t_profile();
        t_end_normal();
        t_range(tcr_pkg::INSIDE, 16'h1000, 16'h1800, 3'h3);
        t_range(tcr_pkg::OUTSIDE, 16'h1800, 16'h1000, 3'h1);
        t_tag_range();
        t_loop();
        t_detail();
        t_event_b();
        t_wrap();
        finish_test();
    end
endmodule // tb_top

// ### bench/tcr_core_model.sv
// Purpose: processor-side model feeding bus cycles, change-of-flow and exec events
// Assumes: driven only from the bench through its tasks
// Notes: released valid, address and data lines show the inverse of the last value
`timescale 1ns/10ps
module tcr_core_model (
    // clock
    input wire logic ref_clk_i,
    // activity toward the block
    output tcr_pkg::tcr_bus_type bus_o,
    output tcr_pkg::tcr_cof_type cof_o,
    output logic exec_o,
    output logic [15:0] exec_addr_o
);
    initial begin
        bus_o = '0;
        cof_o = '0;
        exec_o = 1'b0;
        exec_addr_o = 16'h0000;
    end
    // one bus cycle plus an idle clock, keeps detail spacing
    task automatic bus_cycle(input tcr_pkg::tcr_cyc_type cyc, input logic [15:0] addr, input logic [15:0] data);
        @(negedge ref_clk_i);
        bus_o = '{valid: 1'b1, rw: 1'b1, word: 1'b1, cyc: cyc, addr: addr, data: data};
        @(negedge ref_clk_i);
        bus_o.valid = 1'b0;
        bus_o.addr = ~addr;
        bus_o.data = ~data;
        @(negedge ref_clk_i);
    endtask
    task automatic cof_event(input tcr_pkg::tcr_cof_kind_type kind, input logic swi, input logic [15:0] addr);
        @(negedge ref_clk_i);
        cof_o = '{valid: 1'b1, kind: kind, swi_or_debug_vec: swi, addr: addr};
        @(negedge ref_clk_i);
        cof_o.valid = 1'b0;
        cof_o.addr = ~addr;
        @(negedge ref_clk_i);
    endtask
    task automatic exec_event(input logic [15:0] addr);
        @(negedge ref_clk_i);
        exec_o = 1'b1;
        exec_addr_o = addr;
        @(negedge ref_clk_i);
        exec_o = 1'b0;
        exec_addr_o = ~addr;
    endtask
endmodule // tcr_core_model

// ### rtl/tcr_defs.svh
// Purpose: constants for the trace capture and range trigger block
// Assumes: included once per compile unit
// Notes: none
`ifndef TCR_DEFS_SVH
`define TCR_DEFS_SVH
`define TCR_INVALID_RD 16'hffff
`define TCR_FLAG_A 0
`define TCR_FLAG_B 1
`define TCR_FLAG_C 2
`define TCR_FLAGS_RST 3'h0
`define TCR_ADDR_RST 16'h0000
`endif

// ### rtl/tcr_pkg.sv
// Purpose: types for the trace capture and range trigger block
// Assumes: nothing
// Notes: none
package tcr_pkg;
    typedef enum logic [3:0] {A_ONLY, A_OR_B, A_THEN_B, EV_B, A_THEN_EV_B,
        A_AND_B, A_AND_NOT_B, INSIDE, OUTSIDE} tcr_trig_type;
    typedef enum logic [1:0] {CAP_NORMAL, CAP_LOOP, CAP_DETAIL, CAP_PROFILE} tcr_cap_type;
    typedef enum logic [1:0] {CYC_PROG, CYC_FREE, CYC_DATA} tcr_cyc_type;
    typedef enum logic [1:0] {COF_SRC, COF_DST, COF_VEC} tcr_cof_kind_type;
    typedef struct packed {
        tcr_trig_type trigger_mode_field;
        tcr_cap_type cap;
        logic begin_trg;
        logic tag_trigger_select;
        logic dir_compare_enable_a;
        logic dir_a;
        logic dir_compare_enable_b;
        logic dir_b;
        logic [15:0] cmp_a;
        logic [15:0] cmp_b;
    } tcr_cfg_type;
    typedef struct packed {
        logic valid;
        logic rw;
        logic word;
        tcr_cyc_type cyc;
        logic [15:0] addr;
        logic [15:0] data;
    } tcr_bus_type;
    typedef struct packed {
        logic valid;
        tcr_cof_kind_type kind;
        logic swi_or_debug_vec;
        logic [15:0] addr;
    } tcr_cof_type;
endpackage : tcr_pkg

// ### rtl/tcr_trace.sv
// Purpose: trace capture, range triggers and trace buffer readout
// Assumes: all inputs from logic on ref_clk_i
// Notes: detail bus cycles arrive at most every other clock
`timescale 1ns/10ps
`include "tcr_defs.svh"
module tcr_trace #(
    parameter int DEPTH = 64,
    parameter int DW = 16,
    parameter int AW = $clog2(DEPTH)
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // control
    input tcr_pkg::tcr_cfg_type cfg_i,
    input wire logic enable_i,
    input wire logic arm_set_i,
    // observed processor activity
    input tcr_pkg::tcr_bus_type bus_i,
    input tcr_pkg::tcr_cof_type cof_i,
    input wire logic exec_i,
    input wire logic [15:0] exec_addr_i,
    // trace window read
    input wire logic rd_i,
    output logic [DW-1:0] rd_data_o,
    output logic rd_valid_o,
    // status
    output logic armed_o,
    output logic [2:0] match_status_reg_o,
    output logic [AW:0] valid_word_count_o,
    output logic trig_o,
    output logic [15:0] comp_c_o,
    output logic c_break_en_o
);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

    logic [DW-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic triggered;
    logic a_seen;
    logic c_valid;
    logic pend_v;
    logic [DW-1:0] pend_d;
    logic [15:0] last_exec;

    function automatic logic [15:0] gran(input logic [15:0] a, input logic w);
        return w ? {a[15:1], 1'b0} : a;
    endfunction

    logic detail, loop1, profile, event_only, begin_eff, tag_a, tag_b, live;
    logic a_stb, b_stb, dok_a, dok_b, eq_a, eq_b, dm, lo, hi;
    logic [15:0] a_adr, b_adr, a_ref, b_ref;
    logic set_a, set_b, trig;
    logic cof_ok, c_hit, det_stb, wr_go, wr_en;
    logic [DW-1:0] wr_data;
    logic arm_go;

    always_comb begin
        detail = cfg_i.cap == tcr_pkg::CAP_DETAIL;
        loop1 = cfg_i.cap == tcr_pkg::CAP_LOOP;
        profile = cfg_i.cap == tcr_pkg::CAP_PROFILE;
        live = armed_o && enable_i && !profile;
        // detail mode demotes event-only modes to plain ones
        event_only = !detail && (cfg_i.trigger_mode_field == tcr_pkg::EV_B ||
            cfg_i.trigger_mode_field == tcr_pkg::A_THEN_EV_B);
        begin_eff = cfg_i.begin_trg || event_only;
        tag_a = cfg_i.tag_trigger_select && !(cfg_i.trigger_mode_field == tcr_pkg::EV_B && !detail);
        tag_b = cfg_i.tag_trigger_select && !event_only;
        // direction only qualifies forced compares
        dok_a = tag_a || !cfg_i.dir_compare_enable_a || bus_i.rw == cfg_i.dir_a;
        dok_b = tag_b || !cfg_i.dir_compare_enable_b || bus_i.rw == cfg_i.dir_b;
        a_stb = tag_a ? exec_i : bus_i.valid && dok_a;
        b_stb = tag_b ? exec_i : bus_i.valid && dok_b;
        // tagged: word granularity; forced: bus address aligned only on word accesses
        a_adr = tag_a ? gran(exec_addr_i, 1'b1) : gran(bus_i.addr, bus_i.word);
        b_adr = tag_b ? gran(exec_addr_i, 1'b1) : gran(bus_i.addr, bus_i.word);
        a_ref = tag_a ? gran(cfg_i.cmp_a, 1'b1) : cfg_i.cmp_a;
        b_ref = tag_b ? gran(cfg_i.cmp_b, 1'b1) : cfg_i.cmp_b;
        eq_a = a_stb && a_adr == a_ref;
        eq_b = b_stb && b_adr == b_ref;
        dm = bus_i.valid && dok_a && bus_i.data == cfg_i.cmp_b;
        lo = a_stb && a_adr >= a_ref;
        hi = a_stb && a_adr <= b_ref;
        set_a = 1'b0;
        set_b = 1'b0;
        trig = 1'b0;
        case (cfg_i.trigger_mode_field)
            tcr_pkg::A_ONLY: begin
                set_a = eq_a;
                trig = eq_a;
            end
            tcr_pkg::A_OR_B: begin
                set_a = eq_a;
                set_b = eq_b;
                trig = eq_a || eq_b;
            end
            tcr_pkg::EV_B: begin
                set_b = eq_b;
                trig = eq_b;
            end
            tcr_pkg::A_THEN_B, tcr_pkg::A_THEN_EV_B: begin
                set_a = eq_a;
                set_b = a_seen && eq_b;
                trig = a_seen && eq_b;
            end
            tcr_pkg::A_AND_B, tcr_pkg::A_AND_NOT_B: begin
                if (cfg_i.tag_trigger_select) begin
                    set_a = eq_a;
                    trig = eq_a;
                end else begin
                    set_a = eq_a && (dm == (cfg_i.trigger_mode_field == tcr_pkg::A_AND_B));
                    set_b = set_a;
                    trig = set_a;
                end
            end
            tcr_pkg::INSIDE: begin
                set_a = lo && hi;
                set_b = lo && hi;
                trig = lo && hi;
            end
            tcr_pkg::OUTSIDE: begin
                set_a = a_stb && !lo;
                set_b = a_stb && !hi;
                trig = a_stb && !(lo && hi);
            end
            default: begin
                trig = 1'b0;
            end
        endcase
        set_a = set_a && live;
        set_b = set_b && live;
        trig = trig && live;
        c_hit = loop1 && c_valid && cof_i.kind == tcr_pkg::COF_SRC && cof_i.addr == comp_c_o;
        cof_ok = cof_i.valid && !(cof_i.kind == tcr_pkg::COF_VEC && cof_i.swi_or_debug_vec) && !c_hit;
        det_stb = bus_i.valid && bus_i.cyc == tcr_pkg::CYC_DATA;
        // begin: from trigger on; end: up to but not the trigger
        wr_go = live && (begin_eff ? (triggered || trig) : !trig);
        if (event_only) begin
            wr_en = live && trig;
        end else if (detail) begin
            wr_en = pend_v || (wr_go && det_stb);
        end else begin
            wr_en = wr_go && cof_ok;
        end
        if (pend_v) begin
            wr_data = pend_d;
        end else if (event_only) begin
            wr_data = bus_i.data;
        end else if (detail) begin
            wr_data = bus_i.addr;
        end else begin
            wr_data = cof_i.addr;
        end
        arm_go = arm_set_i && enable_i && !profile;
    end

    // capture-active control
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            armed_o <= 1'b0;
        end else if (!enable_i || profile) begin
            armed_o <= 1'b0;
        end else if (arm_go) begin
            armed_o <= 1'b1;
        end else if (trig && !begin_eff) begin
            armed_o <= 1'b0;
        end else if (begin_eff && wr_en && valid_word_count_o == FULL - 1'b1) begin
            armed_o <= 1'b0;
        end
    end

    // trigger sequence state
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || arm_go) begin
            triggered <= 1'b0;
            a_seen <= 1'b0;
            trig_o <= 1'b0;
        end else begin
            triggered <= triggered || trig;
            a_seen <= a_seen || set_a;
            trig_o <= trig;
        end
    end

    // match flags, set wins over the arm clear
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            match_status_reg_o <= `TCR_FLAGS_RST;
        end else begin
            match_status_reg_o[`TCR_FLAG_A] <= set_a || (match_status_reg_o[`TCR_FLAG_A] && !arm_go);
            match_status_reg_o[`TCR_FLAG_B] <= set_b || (match_status_reg_o[`TCR_FLAG_B] && !arm_go);
            match_status_reg_o[`TCR_FLAG_C] <= (live && c_hit && cof_i.valid) ||
                (match_status_reg_o[`TCR_FLAG_C] && !arm_go);
        end
    end

    // comparator c in loop mode
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            comp_c_o <= `TCR_ADDR_RST;
            c_valid <= 1'b0;
            c_break_en_o <= 1'b0;
        end else begin
            c_break_en_o <= enable_i && !loop1 && !profile;
            if (arm_go && loop1) begin
                comp_c_o <= `TCR_ADDR_RST;
                c_valid <= 1'b0;
            end else if (loop1 && wr_en) begin
                comp_c_o <= wr_data;
                c_valid <= 1'b1;
            end
        end
    end

    // detail data follows its address
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            pend_v <= 1'b0;
            pend_d <= '0;
        end else begin
            pend_v <= detail && !pend_v && wr_go && det_stb;
            pend_d <= bus_i.data;
        end
    end

    // circular buffer write side
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || arm_go) begin
            wr_ptr <= '0;
            valid_word_count_o <= '0;
        end else if (wr_en) begin
            mem[wr_ptr] <= wr_data;
            wr_ptr <= wr_ptr + 1'b1;
            if (valid_word_count_o != FULL) begin
                valid_word_count_o <= valid_word_count_o + 1'b1;
            end
        end
    end

    // read pointer follows the oldest entry
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || arm_go) begin
            rd_ptr <= '0;
        end else if (wr_en && valid_word_count_o == FULL) begin
            rd_ptr <= wr_ptr + 1'b1;
        end else if (rd_i && enable_i && !armed_o && !profile) begin
            rd_ptr <= rd_ptr + 1'b1;
        end
    end

    // trace window
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rd_data_o <= `TCR_INVALID_RD;
            rd_valid_o <= 1'b0;
            last_exec <= `TCR_ADDR_RST;
        end else begin
            if (exec_i) begin
                last_exec <= exec_addr_i;
            end
            rd_valid_o <= rd_i && enable_i && (profile || !armed_o);
            if (rd_i && profile) begin
                rd_data_o <= last_exec;
            end else if (rd_i && enable_i && !armed_o) begin
                rd_data_o <= mem[rd_ptr];
            end else if (rd_i) begin
                rd_data_o <= `TCR_INVALID_RD;
            end
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_inside_both;
        live && cfg_i.trigger_mode_field == tcr_pkg::INSIDE && lo && hi && !arm_go
            |=> match_status_reg_o[1:0] == 2'h3 && trig_o;
    endproperty
    a_inside_both: assert property (p_inside_both) else $error("inside hit missed");
    property p_inside_single;
        live && cfg_i.trigger_mode_field == tcr_pkg::INSIDE && (lo != hi) &&
            match_status_reg_o == 3'h0 |=> match_status_reg_o[1:0] == 2'h0 && !trig_o;
    endproperty
    a_inside_single: assert property (p_inside_single) else $error("single edge flagged");
    property p_outside;
        live && cfg_i.trigger_mode_field == tcr_pkg::OUTSIDE && a_stb && !lo && !arm_go
            |=> match_status_reg_o[0] && trig_o;
    endproperty
    a_outside: assert property (p_outside) else $error("outside low missed");
    property p_end_disarm;
        trig && !begin_eff && !arm_go |=> !armed_o;
    endproperty
    a_end_disarm: assert property (p_end_disarm) else $error("end trigger kept armed");
    property p_full_disarm;
        begin_eff && wr_en && valid_word_count_o == FULL - 1'b1 && !arm_go
            |=> !armed_o && valid_word_count_o == FULL;
    endproperty
    a_full_disarm: assert property (p_full_disarm) else $error("full buffer kept armed");
    property p_arm_clear;
        arm_go |=> match_status_reg_o == 3'h0 ##0 armed_o ##0 valid_word_count_o == '0;
    endproperty
    a_arm_clear: assert property (p_arm_clear) else $error("arming left state");
    property p_rd_armed;
        rd_i && armed_o && !profile && !wr_en |=> rd_data_o == `TCR_INVALID_RD && $stable(rd_ptr);
    endproperty
    a_rd_armed: assert property (p_rd_armed) else $error("armed read moved");
    property p_rd_adv;
        rd_i && enable_i && !armed_o && !profile && !wr_en && !arm_go
            |=> rd_ptr == $past(rd_ptr) + 1'b1 && $stable(valid_word_count_o) && rd_valid_o;
    endproperty
    a_rd_adv: assert property (p_rd_adv) else $error("read pointer stuck");
    property p_profile;
        profile && !arm_go |=> $stable(valid_word_count_o) && !armed_o;
    endproperty
    a_profile: assert property (p_profile) else $error("profile captured");
    property p_loop_load;
        loop1 && wr_en && !arm_go |=> comp_c_o == $past(wr_data) && !c_break_en_o;
    endproperty
    a_loop_load: assert property (p_loop_load) else $error("loop compare not loaded");
    property p_det_pair;
        detail && wr_go && det_stb && !pend_v && !arm_go && valid_word_count_o < FULL - 1'b1
            |=> valid_word_count_o == $past(valid_word_count_o) + 1'b1
            ##1 valid_word_count_o == $past(valid_word_count_o, 2) + 2'h2;
    endproperty
    a_det_pair: assert property (p_det_pair) else $error("detail data not paired");
    property p_c_off;
        loop1 || profile |=> !c_break_en_o;
    endproperty
    a_c_off: assert property (p_c_off) else $error("loop compare break enabled");
    property p_event_store;
        event_only && trig && !arm_go |=> valid_word_count_o == $past(valid_word_count_o) + 1'b1;
    endproperty
    a_event_store: assert property (p_event_store) else $error("event data not stored");
    property p_begin_wait;
        begin_eff && live && !triggered && !trig && !pend_v && !arm_go |=> $stable(valid_word_count_o);
    endproperty
    a_begin_wait: assert property (p_begin_wait) else $error("stored before begin trigger");
    property p_wrap_oldest;
        wr_en && valid_word_count_o == FULL && !arm_go |=> valid_word_count_o == FULL && rd_ptr == wr_ptr;
    endproperty
    a_wrap_oldest: assert property (p_wrap_oldest) else $error("read start not oldest");

    c_end_trig: cover property (trig && !begin_eff);
    c_full: cover property (valid_word_count_o == FULL && !armed_o);
    c_loop_hit: cover property (live && c_hit && cof_i.valid);
    c_read: cover property (rd_valid_o && !armed_o);
endmodule // tcr_trace
